// File: core/key_reset_detect.sv
`timescale 1ns/10ps
`include "port_ctrl_params.svh"

module key_reset_detect (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// configuration and keys
	input wire port_ctrl_pkg::key_cfg_e keyCfg,
	input wire logic [3:0] keyIn,
	// reset request
	output logic keyReset
);
	import port_ctrl_pkg::*;

	function automatic logic [3:0] lowMask(input key_cfg_e cfg);
		unique case (cfg)
			KEY_OFF: lowMask = 4'h0;
			KEY_TWO: lowMask = 4'h3;
			KEY_THREE: lowMask = 4'h7;
			KEY_FOUR: lowMask = 4'hF;
		endcase
	endfunction

	// registered so a glitch on the keys cannot pulse the reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			keyReset <= 1'b0;
		end else begin
			keyReset <= (keyCfg != KEY_OFF) && ((keyIn & lowMask(keyCfg)) == 4'h0);
		end
	end
endmodule

// File: core/port_clock_div.sv
`timescale 1ns/10ps
`include "port_ctrl_params.svh"

module port_clock_div #(
	parameter int CNT_W = 14
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// source and control
	input wire logic srcTick,
	input wire logic runEn,
	input wire port_ctrl_pkg::clk_div_t divCode,
	// divided enable
	output logic portClkEn
);
	import port_ctrl_pkg::*;

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cntMask;

	// power-of-two ratio; the all-ones code passes every source tick
	function automatic logic [CNT_W-1:0] ratioMask(input clk_div_t code);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		if (code == `DIV_BYPASS) begin
			ratioMask = '0;
		end else begin
			ratioMask = (one << code) - one;
		end
	endfunction

	assign cntMask = ratioMask(divCode);

	// counter freezes while stopped so debug resumes mid-period
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (srcTick && runEn) begin
			cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	assign portClkEn = srcTick && runEn && ((cnt_reg & cntMask) == cntMask);
endmodule

// File: core/port_ctrl_params.svh
`ifndef PORT_CTRL_PARAMS_SVH
`define PORT_CTRL_PARAMS_SVH

// register byte addresses
`define ADDR_MODE 8'h00
`define ADDR_FUNC 8'h04
`define ADDR_CLKCTL 8'h08
`define ADDR_SUMMARY 8'h0C
`define ADDR_FLAG 8'h10
`define ADDR_IRQEN 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_MASK 8'h1C

// clock control field positions
`define CLK_RUNDBG_BIT 8
`define CLK_DIV_HI 7
`define CLK_DIV_LO 4
`define CLK_KEY_HI 3
`define CLK_KEY_LO 2
`define CLK_SRC_HI 1
`define CLK_SRC_LO 0

// reset values
`define RST_WORD 16'h0000
`define RST_BYTE 8'h00
`define RST_NIB 4'h0
`define RST_CNT 14'h0000

// status bit positions
`define EV_KEY 0
`define EV_GROUP 1
`define EV_REFUSE 2
`define EV_W 3

// divider code that bypasses division
`define DIV_BYPASS 4'hF

`endif

// File: core/port_ctrl_pkg.sv
package port_ctrl_pkg;
	typedef enum logic [1:0] {
		SRC_INTERNAL,
		SRC_LOW_XTAL,
		SRC_HIGH_OSC,
		SRC_EXTERNAL
	} clk_src_e;

	typedef enum logic [1:0] {
		KEY_OFF,
		KEY_TWO,
		KEY_THREE,
		KEY_FOUR
	} key_cfg_e;

	typedef logic [3:0] clk_div_t;
endpackage

// File: core/port_mux_clock_keyreset.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "port_ctrl_params.svh"

module port_mux_clock_keyreset #(
	parameter int NPINS = 8,
	parameter int NGROUPS = 13,
	parameter logic [NGROUPS-1:0] GROUP_IRQ_PRESENT = 13'h1FFF,
	parameter logic [3:0] SRC_PRESENT = 4'h7
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// pin routing
	output logic [NPINS-1:0] pinPeriphEn,
	output logic [4*NPINS-1:0] pinFuncEn,
	// port clock
	input wire logic [3:0] srcTick,
	input wire logic debugMode,
	output logic portClkEn,
	// key-entry reset
	input wire logic [3:0] keyIn,
	output logic keyReset,
	// interrupts
	input wire logic [NPINS-1:0] portIrqEvent,
	input wire logic [NGROUPS-1:1] otherGroupPending,
	output logic irq
);
	import port_ctrl_pkg::*;

	logic [NPINS-1:0] mode_reg;
	logic [2*NPINS-1:0] func_reg;
	logic runDbg_reg;
	clk_div_t div_reg;
	key_cfg_e key_reg;
	clk_src_e src_reg;
	logic [NPINS-1:0] flag_reg;
	logic [NPINS-1:0] irqEn_reg;
	logic [`EV_W-1:0] status_reg;
	logic [`EV_W-1:0] status_next;
	logic [`EV_W-1:0] mask_reg;
	logic [NGROUPS-1:0] summaryPrev_reg;
	logic keyPrev_reg;
	logic [NGROUPS-1:0] summary;
	logic wrMode;
	logic wrFunc;
	logic wrClk;
	logic wrFlag;
	logic wrIrqEn;
	logic wrMask;
	logic rdStatus;
	logic srcOk;
	logic refused;
	logic selTick;
	logic runEn;
	logic [`EV_W-1:0] events;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		hit = (a == target);
	endfunction

	assign wrMode = regWr && hit(regAddr, `ADDR_MODE);
	assign wrFunc = regWr && hit(regAddr, `ADDR_FUNC);
	assign wrClk = regWr && hit(regAddr, `ADDR_CLKCTL);
	assign wrFlag = regWr && hit(regAddr, `ADDR_FLAG);
	assign wrIrqEn = regWr && hit(regAddr, `ADDR_IRQEN);
	assign wrMask = regWr && hit(regAddr, `ADDR_MASK);
	assign rdStatus = regRd && hit(regAddr, `ADDR_STATUS);

	// pin mode and function select
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= '0;
			func_reg <= '0;
		end else begin
			if (wrMode) begin
				mode_reg <= regWdata[NPINS-1:0];
			end
			if (wrFunc) begin
				func_reg <= regWdata[2*NPINS-1:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pinPeriphEn <= '0;
			pinFuncEn <= '0;
		end else begin
			pinPeriphEn <= mode_reg;
			for (int p = 0; p < NPINS; p++) begin
				for (int f = 0; f < 4; f++) begin
					pinFuncEn[4*p+f] <= mode_reg[p] && (func_reg[2*p +: 2] == 2'(f));
				end
			end
		end
	end

	// clock control; a refused source write still updates the other fields
	assign srcOk = SRC_PRESENT[regWdata[`CLK_SRC_HI:`CLK_SRC_LO]];
	assign refused = wrClk && !srcOk;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			runDbg_reg <= 1'b0;
			div_reg <= `RST_NIB;
			key_reg <= KEY_OFF;
			src_reg <= SRC_INTERNAL;
		end else if (wrClk) begin
			runDbg_reg <= regWdata[`CLK_RUNDBG_BIT];
			div_reg <= regWdata[`CLK_DIV_HI:`CLK_DIV_LO];
			key_reg <= key_cfg_e'(regWdata[`CLK_KEY_HI:`CLK_KEY_LO]);
			if (srcOk) begin
				src_reg <= clk_src_e'(regWdata[`CLK_SRC_HI:`CLK_SRC_LO]);
			end
		end
	end

	assign selTick = srcTick[src_reg];
	assign runEn = !debugMode || runDbg_reg;

	port_clock_div #(
		.CNT_W(14)
	) port_clock_div_i (
		.mclk(mclk),
		.rst_n(rst_n),
		.srcTick(selTick),
		.runEn(runEn),
		.divCode(div_reg),
		.portClkEn(portClkEn)
	);

	key_reset_detect key_reset_detect_i (
		.mclk(mclk),
		.rst_n(rst_n),
		.keyCfg(key_reg),
		.keyIn(keyIn),
		.keyReset(keyReset)
	);

	// port flags: an event in the clearing cycle survives
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= (flag_reg & ~(wrFlag ? regWdata[NPINS-1:0] : '0)) | portIrqEvent;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqEn_reg <= '0;
		end else if (wrIrqEn) begin
			irqEn_reg <= regWdata[NPINS-1:0];
		end
	end

	// group summary follows the flags live, so it clears with them
	always_comb begin
		summary = {otherGroupPending, |(flag_reg & irqEn_reg)} & GROUP_IRQ_PRESENT;
	end

	// events and sticky status
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			summaryPrev_reg <= '0;
			keyPrev_reg <= 1'b0;
		end else begin
			summaryPrev_reg <= summary;
			keyPrev_reg <= keyReset;
		end
	end

	always_comb begin
		events = '0;
		events[`EV_KEY] = keyReset && !keyPrev_reg;
		events[`EV_GROUP] = |(summary & ~summaryPrev_reg);
		events[`EV_REFUSE] = refused;
		status_next = (rdStatus ? '0 : status_reg) | events;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_reg <= '0;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= '0;
		end else if (wrMask) begin
			mask_reg <= regWdata[`EV_W-1:0];
		end
	end

	assign irq = |(status_reg & mask_reg);

	// read port; unmapped addresses read zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= `RST_WORD;
		end else if (regRd) begin
			regRdata <= `RST_WORD;
			unique case (regAddr)
				`ADDR_MODE: regRdata[NPINS-1:0] <= mode_reg;
				`ADDR_FUNC: regRdata[2*NPINS-1:0] <= func_reg;
				`ADDR_CLKCTL: regRdata[`CLK_RUNDBG_BIT:0] <= {runDbg_reg, div_reg, key_reg, src_reg};
				`ADDR_SUMMARY: regRdata[NGROUPS-1:0] <= summary;
				`ADDR_FLAG: regRdata[NPINS-1:0] <= flag_reg;
				`ADDR_IRQEN: regRdata[NPINS-1:0] <= irqEn_reg;
				`ADDR_STATUS: regRdata[`EV_W-1:0] <= status_reg;
				`ADDR_MASK: regRdata[`EV_W-1:0] <= mask_reg;
				default: regRdata <= `RST_WORD;
			endcase
		end
	end

	// checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence s_gpio_pin0;
		!mode_reg[0];
	endsequence

	sequence s_pin1_func2;
		mode_reg[1] && (func_reg[3:2] == 2'h2);
	endsequence

	property p_route;
		s_gpio_pin0 |=> (pinFuncEn[3:0] == 4'h0) && !pinPeriphEn[0];
	endproperty
	a_route: assert property (p_route) else $error("gpio pin routed to a function");

	property p_func;
		s_pin1_func2 |=> pinFuncEn[7:4] == 4'h4;
	endproperty
	a_func: assert property (p_func) else $error("function code not applied");

	property p_debug_stop;
		debugMode && !runDbg_reg |-> !portClkEn;
	endproperty
	a_debug_stop: assert property (p_debug_stop) else $error("port clock ran in debug");

	property p_div_one;
		(div_reg == 4'h0) && selTick && !debugMode |-> portClkEn;
	endproperty
	a_div_one: assert property (p_div_one) else $error("ratio one missed a tick");

	property p_div_gate;
		portClkEn |-> selTick;
	endproperty
	a_div_gate: assert property (p_div_gate) else $error("port clock without source tick");

	property p_key_two;
		(key_reg == KEY_TWO) && (keyIn[1:0] == 2'h0) |=> keyReset;
	endproperty
	a_key_two: assert property (p_key_two) else $error("key reset not raised");

	property p_key_off;
		(key_reg == KEY_OFF) |=> !keyReset;
	endproperty
	a_key_off: assert property (p_key_off) else $error("key reset while disabled");

	property p_refuse;
		refused |=> (src_reg == $past(src_reg)) && status_reg[`EV_REFUSE];
	endproperty
	a_refuse: assert property (p_refuse) else $error("unsupported source accepted");

	property p_w1c;
		wrFlag && regWdata[0] && !portIrqEvent[0] |=>
			!flag_reg[0] && (summary[0] == |(flag_reg[NPINS-1:1] & irqEn_reg[NPINS-1:1]));
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

	property p_w0_keep;
		wrFlag && !regWdata[0] && flag_reg[0] |=> flag_reg[0];
	endproperty
	a_w0_keep: assert property (p_w0_keep) else $error("flag lost on zero write");

	property p_masked_port;
		!irqEn_reg[0] && (irqEn_reg[NPINS-1:1] == '0) |-> !summary[0];
	endproperty
	a_masked_port: assert property (p_masked_port) else $error("disabled port set summary");

	property p_reserved;
		regRd && hit(regAddr, `ADDR_CLKCTL) |=> regRdata[15:9] == 7'h00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved clock bits nonzero");
endmodule

// File: test/osc_key_model.sv
`timescale 1ns/10ps

module osc_key_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// switches held down by the bench
	input wire logic [3:0] keyPress,
	// toward the port block
	output logic [3:0] keyIn,
	output logic [3:0] srcTick
);
	logic [7:0] phase;

	// pull-ups: a released switch reads high
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			keyIn <= 4'hF;
		end else begin
			keyIn <= ~keyPress;
		end
	end

	// source k ticks every k+1 cycles, so a wrong pick shows in a count
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 8'h00;
			srcTick <= 4'h0;
		end else begin
			phase <= phase + 8'h01;
			for (int k = 0; k < 4; k++) begin
				srcTick[k] <= (phase % (k + 1)) == 0;
			end
		end
	end
endmodule

// File: test/port_mux_clock_keyreset_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end

module port_mux_clock_keyreset_test;
	import port_ctrl_pkg::*;
	logic mclk = 0, rst_n = 0, regWr = 0, regRd = 0, debugMode = 0, rdSeen = 0, irq, keyReset, portClkEn;
	logic [7:0] regAddr = 8'h00, portIrqEvent = 8'h00, pinPeriphEn, m;
	logic [15:0] regWdata = 16'h0000, regRdata, rnd = 16'h0028, f, eq;
	logic [31:0] pinFuncEn, ef;
	logic [3:0] srcTick, keyIn, keyPress = 4'h0;
	logic [12:1] otherGroupPending = 12'h000;
	logic [15:0] q[$];
	logic [15:0] cc[7] = '{16'h0001, 16'h0021, 16'h0042, 16'h00F0, 16'h0021, 16'h0121, 16'h0190};
	logic [15:0] ce[7] = '{16'h0040, 16'h0010, 16'h0004, 16'h0040, 16'h0000, 16'h0010, 16'h0002};
	int cs[7] = '{1, 1, 2, 0, 1, 1, 0};
	int errors = 0, check_count = 0, n;

	always #50 mclk = ~mclk;

	// bit 12 left out to see an absent group read zero
	port_mux_clock_keyreset #(.GROUP_IRQ_PRESENT(13'h0FFF)) port_mux_clock_keyreset_i (.mclk(mclk), .rst_n(rst_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.pinPeriphEn(pinPeriphEn), .pinFuncEn(pinFuncEn), .srcTick(srcTick), .debugMode(debugMode),
		.portClkEn(portClkEn), .keyIn(keyIn), .keyReset(keyReset), .portIrqEvent(portIrqEvent),
		.otherGroupPending(otherGroupPending), .irq(irq));

	osc_key_model osc_key_model_i (.mclk(mclk), .rst_n(rst_n), .keyPress(keyPress), .keyIn(keyIn),
		.srcTick(srcTick));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic finish_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// strobes drop a cycle later, so back-to-back calls never touch one signal twice
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		q.push_back(e);
		@(posedge mclk);
		regRd <= 1'b0;
	endtask

	// read data stands from the cycle after the strobe until the next read
	always @(posedge mclk) begin
		if (rdSeen) begin
			if (q.size() == 0) begin
				errors++;
				$display("unexpected regRdata exp none got %h", regRdata);
			end else begin
				eq = q.pop_front();
				`CHK("regRdata", eq, regRdata)
			end
		end
		rdSeen <= regRd;
	end

	task automatic count(input int s, input logic [15:0] e, input logic [15:0] ctl, input logic dbg, input int nt);
		int tk;
		int lim;
		logic [15:0] pl;
		@(posedge mclk);
		debugMode <= dbg;
		wr(8'h08, ctl);
		tk = 0;
		lim = 0;
		pl = 16'h0000;
		while (tk < nt && lim < 2000) begin
			@(negedge mclk);
			tk += srcTick[s];
			pl += {15'h0000, portClkEn};
			lim++;
		end
		if (lim == 2000) begin
			errors++;
			finish_test();
		end
		`CHK("portClkEn count", e, pl)
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		errors++;
		finish_test();
	end

	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		for (int a = 0; a < 9; a++) begin
			rd(8'(4 * a), 16'h0000);
		end
		$display("test reset done");

		// first pass sets every function code, then random patterns
		for (int i = 0; i < 5; i++) begin
			rnd = lfsr(rnd);
			m = (i == 0) ? 8'h0F : rnd[15:8];
			rnd = lfsr(rnd);
			f = (i == 0) ? 16'hE4E4 : rnd;
			ef = 32'h0000_0000;
			for (int p = 0; p < 8; p++) begin
				if (m[p]) begin
					ef[4 * p + f[2 * p +: 2]] = 1'b1;
				end
			end
			wr(8'h00, {8'h00, m});
			wr(8'h04, f);
			repeat (3) @(posedge mclk);
			@(negedge mclk);
			`CHK("pinPeriphEn", m, pinPeriphEn)
			`CHK("pinFuncEn", ef, pinFuncEn)
			rd(8'h04, f);
		end
		$display("test routing done");

		// missing external input: source stays, other fields land
		wr(8'h08, 16'hFFFF);
		rd(8'h08, 16'h01FC);
		rd(8'h18, 16'h0004);
		for (int i = 0; i < 7; i++) begin
			count(cs[i], ce[i], cc[i], i >= 4, (i == 6) ? 1024 : 64);
		end
		$display("test clock done");

		for (int c = 0; c < 4; c++) begin
			wr(8'h08, 16'(c << 2));
			for (int k = 0; k < 16; k++) begin
				@(posedge mclk);
				keyPress <= k[3:0];
				repeat (3) @(posedge mclk);
				@(negedge mclk);
				`CHK("keyReset", (c != 0) && ((~k[3:0] & 4'((2 << c) - 1)) == 4'h0), keyReset)
			end
		end
		@(posedge mclk);
		keyPress <= 4'h0;
		rd(8'h18, 16'h0001);
		$display("test key done");

		wr(8'h14, 16'h0001);
		wr(8'h1C, 16'h0002);
		@(posedge mclk);
		portIrqEvent <= 8'h02;
		@(posedge mclk);
		portIrqEvent <= 8'h00;
		rd(8'h10, 16'h0002);
		rd(8'h0C, 16'h0000);
		@(negedge mclk);
		`CHK("irq", 1'b0, irq)
		@(posedge mclk);
		portIrqEvent <= 8'h01;
		@(posedge mclk);
		portIrqEvent <= 8'h00;
		rd(8'h0C, 16'h0001);
		n = 0;
		while (irq !== 1'b1 && n < 8) begin
			@(negedge mclk);
			n++;
		end
		`CHK("irq", 1'b1, irq)
		rd(8'h18, 16'h0002);
		repeat (2) @(negedge mclk);
		`CHK("irq", 1'b0, irq)
		wr(8'h10, 16'h0000);
		rd(8'h10, 16'h0003);
		wr(8'h10, 16'h0001);
		rd(8'h10, 16'h0002);
		rd(8'h0C, 16'h0000);
		@(posedge mclk);
		otherGroupPending <= 12'hFFF;
		rd(8'h0C, 16'h0FFE);
		$display("test summary done");
		finish_test();
	end
endmodule
